// ===== verilog/pwm_cfg_pkg.sv
// Operation
// - channel one prescale select bits 31:30
// - channel two independent prescale, same ratios
// - channel one on delay, 11 bits 18:8
// - channel two on delay, 11 bits 18:8
// - channel two delay only under serial control
// - channel one word at address 0x06
// - channel two word at address 0x07
// - pwm frequency is base over period plus one
// - duty zero is off, duty>=period full on
package pwm_cfg_pkg;
    // ********************
    // register map
    // ********************
    localparam logic [6:0]  chan_one_index    = 7'h06;
    localparam logic [6:0]  chan_two_index    = 7'h07;
    localparam logic [6:0]  period_one_index  = 7'h10;
    localparam logic [6:0]  period_two_index  = 7'h11;
    localparam logic [6:0]  control_index     = 7'h12;
    localparam int          presc_hi          = 31;
    localparam int          presc_lo          = 30;
    localparam int          delay_hi          = 18;
    localparam int          delay_lo          = 8;
    localparam int          duty_lo           = 16;
    localparam logic [31:0] cfg_mask          = 32'hc007ff00;
    localparam logic [31:0] reset_value       = 32'h00000000;
    localparam logic [31:0] period_mask       = 32'h07ff07ff;
    localparam logic [4:0]  div_one_last      = 5'h00;
    localparam logic [4:0]  div_two_last      = 5'h01;
    localparam logic [4:0]  div_four_last     = 5'h03;
    localparam logic [4:0]  div_twenty_last   = 5'h13;
endpackage : pwm_cfg_pkg

// ===== verilog/pwm_prescale_on_delay_cfg.sv
`timescale 1ns/1ns
module pwm_prescale_on_delay_cfg
(
    // system
    input  wire logic        clk,
    input  wire logic        srst,
    // avalon-mm slave
    input  wire logic [8:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // pwm outputs
    output logic             bridge_one_outputs,
    output logic             bridge_two_outputs
);
    import pwm_cfg_pkg::*;

    // ********************
    // registers
    // ********************
    logic [31:0] chan_one_prescale_on_delay;
    logic [31:0] chan_two_prescale_on_delay;
    logic [31:0] period_one;
    logic [31:0] period_two;
    logic [1:0]  serial_ctrl;
    logic        done;

    wire         req      = (read | write) & ~done;
    wire  [6:0]  idx      = address[8:2];
    wire         hit_one  = idx == chan_one_index;
    wire         hit_two  = idx == chan_two_index;
    wire         hit_p1   = idx == period_one_index;
    wire         hit_p2   = idx == period_two_index;
    wire         hit_ctl  = idx == control_index;
    wire  [31:0] wmask    = writedata & cfg_mask;
    wire  [31:0] next_readdata =
        hit_one ? chan_one_prescale_on_delay :
        hit_two ? chan_two_prescale_on_delay :
        hit_p1  ? period_one :
        hit_p2  ? period_two :
        hit_ctl ? {30'h00000000, serial_ctrl} : 32'h00000000;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            chan_one_prescale_on_delay <= reset_value;
            chan_two_prescale_on_delay <= reset_value;
            period_one  <= reset_value;
            period_two  <= reset_value;
            serial_ctrl <= 2'h0;
            done        <= 1'b0;
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
        end
        else
        begin
            done        <= req;
            waitrequest <= ~req;
            if (req && read)
                readdata <= next_readdata;
            if (req && write && hit_one)
                chan_one_prescale_on_delay <= wmask;
            if (req && write && hit_two)
                chan_two_prescale_on_delay <= wmask;
            if (req && write && hit_p1)
                period_one <= writedata & period_mask;
            if (req && write && hit_p2)
                period_two <= writedata & period_mask;
            if (req && write && hit_ctl)
                serial_ctrl <= writedata[1:0];
        end
    end

    // ********************
    // channels
    // ********************
    pwm_chan one
    (
        .clk      (clk),
        .srst     (srst),
        .presc    (chan_one_prescale_on_delay[presc_hi:presc_lo]),
        .delay    (chan_one_prescale_on_delay[delay_hi:delay_lo]),
        .period   (period_one[10:0]),
        .duty     (period_one[duty_lo+10:duty_lo]),
        .serial   (serial_ctrl[0]),
        .pwm_out  (bridge_one_outputs)
    );
    pwm_chan two
    (
        .clk      (clk),
        .srst     (srst),
        .presc    (chan_two_prescale_on_delay[presc_hi:presc_lo]),
        .delay    (chan_two_prescale_on_delay[delay_hi:delay_lo]),
        .period   (period_two[10:0]),
        .duty     (period_two[duty_lo+10:duty_lo]),
        .serial   (serial_ctrl[1]),
        .pwm_out  (bridge_two_outputs)
    );

    // ********************
    // assertions
    // ********************
    read_one_word_a: assert property (@(posedge clk) disable iff (srst)
        (read && !waitrequest && address[8:2] == chan_one_index) |->
        readdata == chan_one_prescale_on_delay)
        else $error("channel one readback wrong");
    zero_bits_a: assert property (@(posedge clk) disable iff (srst)
        (chan_two_prescale_on_delay & ~cfg_mask) == 32'h00000000)
        else $error("unused bits not zero");

    zero_one_bits_a: assert property (@(posedge clk) disable iff (srst)
        (chan_one_prescale_on_delay & ~cfg_mask) == 32'h00000000)
        else $error("channel one unused bits not zero");

    read_two_word_a: assert property (@(posedge clk) disable iff (srst)
        (read && !waitrequest && idx == chan_two_index) |->
        readdata == chan_two_prescale_on_delay)
        else $error("channel two readback wrong");

    write_one_word_a: assert property (@(posedge clk) disable iff (srst)
        (write && !waitrequest && idx == chan_one_index) |->
        chan_one_prescale_on_delay == wmask)
        else $error("channel one write lost");

    write_two_word_a: assert property (@(posedge clk) disable iff (srst)
        (write && !waitrequest && idx == chan_two_index) |->
        chan_two_prescale_on_delay == wmask)
        else $error("channel two write lost");

    answer_once_a: assert property (@(posedge clk) disable iff (srst)
        !waitrequest |=> waitrequest)
        else $error("waitrequest low twice in a row");
endmodule : pwm_prescale_on_delay_cfg

module pwm_chan
    import pwm_cfg_pkg::*;
#(
    // sizing
    parameter int count_width = 11
)
(
    // control
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic [1:0]             presc,
    input  wire logic [count_width-1:0] delay,
    input  wire logic [count_width-1:0] period,
    input  wire logic [count_width-1:0] duty,
    input  wire logic                   serial,
    // output
    output logic                        pwm_out
);

    // ********************
    // parameter check
    // ********************
    if (count_width < 1 || count_width > 16)
    begin : bad_width
        $error("count_width outside 1 to 16");
    end

    // ********************
    // base frequency divider
    // ********************
    logic [4:0]             div;
    wire  [4:0]             last     = presc == 2'h0 ? div_one_last  :
                                       presc == 2'h1 ? div_two_last  :
                                       presc == 2'h2 ? div_four_last : div_twenty_last;
    wire                    tick     = div >= last;
    wire  [4:0]             next_div = tick ? 5'h00 : div + 5'h01;

    // ********************
    // period, duty and on delay
    // ********************
    logic [count_width-1:0] cnt;
    logic [count_width-1:0] dly;
    wire                    wrap     = cnt >= period;
    wire  [count_width-1:0] next_cnt = wrap ? '0 : cnt + 1'b1;
    wire                    delay_ok = dly >= delay;
    wire                    dly_step = serial && tick && !delay_ok;
    wire                    on       = (duty != '0) && (duty >= period || cnt < duty);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            div     <= 5'h00;
            cnt     <= '0;
            dly     <= '0;
            pwm_out <= 1'b0;
        end
        else
        begin
            div <= next_div;
            if (!serial)
                dly <= '0;
            else if (dly_step)
                dly <= dly + 1'b1;
            if (tick)
                cnt <= next_cnt;
            pwm_out <= serial && delay_ok && on;
        end
    end

    // ********************
    // assertions
    // ********************
    zero_duty_a: assert property (@(posedge clk) disable iff (srst)
        (duty == '0) |=> !pwm_out)
        else $error("zero duty drove output");

    full_duty_a: assert property (@(posedge clk) disable iff (srst)
        (serial && delay_ok && duty != '0 && duty >= period) |=> pwm_out)
        else $error("full duty left output low");

    serial_off_a: assert property (@(posedge clk) disable iff (srst)
        !serial |=> !pwm_out)
        else $error("output active without serial control");

    held_delay_a: assert property (@(posedge clk) disable iff (srst)
        (serial && !delay_ok) |=> !pwm_out)
        else $error("output active during on delay");

    div_restart_a: assert property (@(posedge clk) disable iff (srst)
        (tick && presc == 2'h3) |=> (presc != 2'h3 || !tick))
        else $error("divide by twenty ticked early");

    wrap_period_a: assert property (@(posedge clk) disable iff (srst)
        (tick && wrap) |=> cnt == '0)
        else $error("period counter did not wrap");
endmodule : pwm_chan

// ===== test/host_model.sv
`timescale 1ns/1ns
module host_model
(
    // system
    input  wire logic        clk,
    // avalon-mm master
    output logic      [8:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    initial
    begin
        {address, read, write, writedata} = '0;
    end
    // ********************
    // one held request, released at the edge waitrequest is low
    // ********************
    task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= w;
        read      <= !w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : xfer
endmodule : host_model

// ===== test/testbench.sv
`timescale 1ns/1ns
module testbench;
    import pwm_cfg_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [8:0]  address;
    logic        read, write, waitrequest, out_one, out_two;
    logic [31:0] writedata, readdata, dummy;
    int          error_cnt = 0, samples_checked = 0, cycles = 0, gap = 0, high = 0;
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    pwm_prescale_on_delay_cfg u_dut (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .bridge_one_outputs(out_one), .bridge_two_outputs(out_two));
    host_model u_host (.clk(clk), .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest));
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32
    task automatic rise_gap(output int gap_cycles, output int high_cycles);
        logic prev;
        int   seen;
        prev        = 1'b1;
        seen        = 0;
        gap_cycles  = 0;
        high_cycles = 0;
        while (seen < 2 && gap_cycles < 200)
        begin
            @(posedge clk);
            if (seen == 1)
            begin
                gap_cycles++;
                if (out_two === 1'b1)
                    high_cycles++;
            end
            if (!prev && out_two === 1'b1)
                seen++;
            prev = out_two;
        end
    endtask : rise_gap
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, dummy);
    endtask : wr
    task automatic rd_check(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] q;
        u_host.xfer(1'b0, a, 32'h00000000, q);
        check32(q, exp);
    endtask : rd_check
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd_check(9'h018, 32'h00000000);
        rd_check(9'h01c, 32'h00000000);
        wr(9'h018, 32'hffffffff);
        rd_check(9'h018, 32'hc007ff00);
        rd_check(9'h01c, 32'h00000000);
        wr(9'h01c, 32'h8002a500);
        rd_check(9'h01c, 32'h8002a500);
        rd_check(9'h000, 32'h00000000);
        $display("register test done");
        wr(9'h01c, 32'h00000000);
        wr(9'h044, 32'h00040004);
        repeat (50) @(posedge clk);
        check32({31'h0, out_two}, 32'h00000000);
        wr(9'h048, 32'h00000002);
        repeat (50) @(posedge clk);
        check32({31'h0, out_two}, 32'h00000001);
        wr(9'h044, 32'h00000004);
        repeat (50) @(posedge clk);
        check32({31'h0, out_two}, 32'h00000000);
        $display("pwm test done");
        wr(9'h01c, 32'h40000000);
        wr(9'h044, 32'h00010004);
        rise_gap(gap, high);
        check32(gap, 32'h0000000a);
        check32(high, 32'h00000002);
        wr(9'h018, 32'hc0000300);
        wr(9'h040, 32'h00010001);
        wr(9'h048, 32'h00000003);
        repeat (41) @(posedge clk);
        check32({31'h0, out_one}, 32'h00000000);
        repeat (20) @(posedge clk);
        check32({31'h0, out_one}, 32'h00000001);
        $display("prescale test done");
        complete_run();
    end
endmodule : testbench
